// ==== rtl/jbs_tap.sv ====
// boundary-scan test access port with in-system programming instructions
// Contract
// (RULE1) sample captures pins, preload loads update cells
// (RULE2) extest drives cells out, captures inputs
// (RULE3) bypass is one bit, one-stage delay
// (RULE4) idcode puts identification between tdi, tdo
// (RULE5) instruction register is ten bits
// (RULE6) boundary length is a per-variant parameter
// (RULE7) no boundary cells: extest/sample select bypass
// (RULE8) id is version, part, maker, one bit
// (RULE9) maker field eleven bits, lsb always one
// (RULE10) version field occupies the highest id bits
// (RULE11) port disabled: pins are user i/o
// (RULE12) decode programming instructions from the port
// (RULE13) security bit blocks every configuration readback
// (RULE14) security cleared only by full reprogramming
// (RULE15) sixteen-state controller, tdo on falling edge
// (RULE16) chosen opcodes, unknown selects bypass, reset loads id
module jbs_tap
  import jbs_pkg::*;
#(
  parameter int BSR_LEN = BSR_LEN_DEFAULT,
  localparam int BSR_W = (BSR_LEN < 2) ? 1 : BSR_LEN
)
(
  input wire logic ref_clk_in,                 // system clock, 200 MHz
  input wire logic resetn_in,                  // async reset, active low
  input wire logic ce_in,                      // clock enable, freezes state
  input wire logic tap_enable_in,              // configuration enables test port
  input wire logic [3:0] pin_in,               // pad levels: tck, tms, tdi, tdo
  output logic [3:0] pin_out,                  // pad drive level
  output logic [3:0] pin_oe_out,               // pad drive enable
  input wire logic [3:0] user_out_in,          // user level for the four pads
  input wire logic [3:0] user_oe_in,           // user enable for the four pads
  input wire logic [BSR_W-1:0] pad_in,         // levels at device pins
  input wire logic [BSR_W-1:0] core_out_in,    // core levels toward pins
  output logic [BSR_W-1:0] pad_out,            // levels driven to pins
  output logic extest_out,                     // pins owned by scan cells
  input wire logic security_bit_in,            // stored security bit
  input wire logic [DR_LEN-1:0] rb_data_in,    // stored configuration word
  output logic rb_req_out,                     // pulse: next readback word
  output logic erase_req_out,                  // pulse: full erase
  output logic secure_req_out,                 // pulse: program security bit
  output logic isp_active_out,                 // programming instruction held
  output logic prog_valid_out,                 // program word available
  input wire logic prog_ready_in,              // programmer takes word
  output logic [DR_LEN-1:0] prog_data_out      // program word
);

  localparam bit HAS_BSR = (BSR_LEN >= 2);

  jbs_pins_s s1_q, s2_q, s3_q, f_q;
  logic tck_prev_q;
  jbs_state_e st_q, st_d;
  logic [IR_LEN-1:0] ir_q, ir_sh_q;
  logic [DR_LEN-1:0] dsh_q;
  logic byp_q;
  logic [BSR_W-1:0] bsr_sh_q, bsr_up_q;
  logic tdo_q, tdo_oe_q;
  logic pend_q, drop_q;
  logic [DR_LEN-1:0] word_q;
  logic rb_q, erase_q, secure_q;
  wire rise, fall, tms, tdi, tlr_hold;
  wire sel_bsr, sel_id, sel_prog, sel_read, sel_dsh, sel_erase, sel_secure;
  wire in_cap_dr, in_sh_dr, in_up_dr, in_cap_ir, in_sh_ir, in_up_ir, in_tlr;
  wire tdo_bit, push_ok, fifo_ready;
  wire [IR_LEN-1:0] ir_next;
  wire [DR_LEN-1:0] st_word;

  // three-stage synchroniser per input; a level counts once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < $bits(jbs_pins_s); g++)
    begin : g_sync
      always_ff @(posedge ref_clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
        begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
          s3_q[g] <= 1'b0;
          f_q[g] <= 1'b0;
        end
        else if (ce_in)
        begin
          s1_q[g] <= pin_in[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          f_q[g] <= (s2_q[g] == s3_q[g]) ? s2_q[g] : f_q[g];
        end
      end
    end
  endgenerate

  // link clock edge detect on the filtered level
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      tck_prev_q <= 1'b0;
    end
    else if (ce_in)
    begin
      tck_prev_q <= f_q.tck;
    end
  end

  assign rise = ce_in & f_q.tck & ~tck_prev_q;
  assign fall = ce_in & ~f_q.tck & tck_prev_q;
  assign tms = f_q.tms;
  assign tdi = f_q.tdi;
  assign tlr_hold = ~tap_enable_in;

  // controller next state, advanced by tms on each rising tck
  always_comb
  begin
    case (st_q)
      ST_TLR:   st_d = tms ? ST_TLR : ST_RTI;
      ST_RTI:   st_d = tms ? ST_SELDR : ST_RTI;
      ST_SELDR: st_d = tms ? ST_SELIR : ST_CAPDR;
      ST_CAPDR: st_d = tms ? ST_EX1DR : ST_SHDR;
      ST_SHDR:  st_d = tms ? ST_EX1DR : ST_SHDR;
      ST_EX1DR: st_d = tms ? ST_UPDR : ST_PSDR;
      ST_PSDR:  st_d = tms ? ST_EX2DR : ST_PSDR;
      ST_EX2DR: st_d = tms ? ST_UPDR : ST_SHDR;
      ST_UPDR:  st_d = tms ? ST_SELDR : ST_RTI;
      ST_SELIR: st_d = tms ? ST_TLR : ST_CAPIR;
      ST_CAPIR: st_d = tms ? ST_EX1IR : ST_SHIR;
      ST_SHIR:  st_d = tms ? ST_EX1IR : ST_SHIR;
      ST_EX1IR: st_d = tms ? ST_UPIR : ST_PSIR;
      ST_PSIR:  st_d = tms ? ST_EX2IR : ST_PSIR;
      ST_EX2IR: st_d = tms ? ST_UPIR : ST_SHIR;
      ST_UPIR:  st_d = tms ? ST_SELDR : ST_RTI;
      default:  st_d = ST_TLR;
    endcase
  end

  // controller state; held in reset while the port is disabled
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      st_q <= ST_TLR;
    end
    else if (ce_in && tlr_hold)
    begin
      st_q <= ST_TLR; // RULE11
    end
    else if (rise)
    begin
      st_q <= st_d; // RULE15
    end
  end

  // state decode
  assign in_tlr = (st_q == ST_TLR);
  assign in_cap_dr = (st_q == ST_CAPDR);
  assign in_sh_dr = (st_q == ST_SHDR);
  assign in_up_dr = (st_q == ST_UPDR);
  assign in_cap_ir = (st_q == ST_CAPIR);
  assign in_sh_ir = (st_q == ST_SHIR);
  assign in_up_ir = (st_q == ST_UPIR);

  // instruction decode; anything unlisted falls to bypass
  assign sel_bsr = HAS_BSR && ((ir_q == OP_EXTEST) || (ir_q == OP_SAMPLE)); // RULE7
  assign sel_id = (ir_q == OP_IDCODE); // RULE4
  assign sel_prog = (ir_q == OP_ISP_PROGRAM); // RULE12
  assign sel_read = (ir_q == OP_ISP_READ); // RULE12
  assign sel_erase = (ir_q == OP_ISP_ERASE);
  assign sel_secure = (ir_q == OP_ISP_SECURE);
  assign sel_dsh = sel_id | sel_prog | sel_read;
  assign ir_next = ir_sh_q;

  // instruction register: capture pattern, shift, update; reset loads identification
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      ir_q <= OP_IDCODE;
      ir_sh_q <= IR_CAPTURE;
    end
    else if (rise)
    begin
      if (in_tlr)
      begin
        ir_q <= OP_IDCODE; // RULE16
      end
      if (in_cap_ir)
      begin
        ir_sh_q <= IR_CAPTURE;
      end
      if (in_sh_ir)
      begin
        ir_sh_q <= {tdi, ir_sh_q[IR_LEN-1:1]}; // RULE5
      end
      if (in_up_ir)
      begin
        ir_q <= ir_next;
      end
    end
  end

  // status word seen when the program register is captured
  assign st_word = DR_LEN'({drop_q, pend_q}) << ST_PEND_BIT;

  // shared 32-bit data register and one-bit bypass
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      dsh_q <= '0;
      byp_q <= 1'b0;
    end
    else if (rise)
    begin
      if (in_cap_dr)
      begin
        byp_q <= 1'b0;
        if (sel_id)
        begin
          dsh_q <= ID_VALUE; // RULE8 RULE9 RULE10
        end
        else if (sel_read)
        begin
          dsh_q <= security_bit_in ? '0 : rb_data_in; // RULE13
        end
        else
        begin
          dsh_q <= st_word;
        end
      end
      if (in_sh_dr)
      begin
        byp_q <= tdi; // RULE3
        dsh_q <= {tdi, dsh_q[DR_LEN-1:1]};
      end
    end
  end

  // boundary cells: capture pins, shift, update onto pins under extest
  generate
    for (g = 0; g < BSR_W; g++)
    begin : g_cell
      wire shin = (g == BSR_W - 1) ? tdi : bsr_sh_q[(g + 1) % BSR_W];
      always_ff @(posedge ref_clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
        begin
          bsr_sh_q[g] <= 1'b0;
          bsr_up_q[g] <= 1'b0;
        end
        else if (rise && sel_bsr)
        begin
          if (in_cap_dr)
          begin
            bsr_sh_q[g] <= pad_in[g]; // RULE1 RULE2
          end
          if (in_sh_dr)
          begin
            bsr_sh_q[g] <= shin; // RULE6
          end
          if (in_up_dr)
          begin
            bsr_up_q[g] <= bsr_sh_q[g]; // RULE1
          end
        end
      end
    end
  endgenerate

  // pins follow the core except under extest
  assign extest_out = HAS_BSR && (ir_q == OP_EXTEST);
  assign pad_out = extest_out ? bsr_up_q : core_out_in; // RULE2

  // serial output selection
  assign tdo_bit = in_sh_ir ? ir_sh_q[0] : sel_bsr ? bsr_sh_q[0] : sel_dsh ? dsh_q[0] : byp_q;

  // tdo and its enable change on falling tck, driven only in shift states
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end
    else if (ce_in && tlr_hold)
    begin
      tdo_oe_q <= 1'b0;
    end
    else if (fall)
    begin
      tdo_q <= tdo_bit; // RULE15
      tdo_oe_q <= in_sh_dr | in_sh_ir; // RULE15
    end
  end

  // program words wait in a holding register until the buffer accepts them
  assign push_ok = rise & in_up_dr & sel_prog & (~pend_q | fifo_ready);

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      pend_q <= 1'b0;
      drop_q <= 1'b0;
      word_q <= '0;
    end
    else if (ce_in)
    begin
      pend_q <= (pend_q & ~fifo_ready) | push_ok;
      if (push_ok)
      begin
        word_q <= dsh_q; // RULE12
      end
      // a refused word sets the drop flag; the set wins over the capture clear
      if (rise && in_up_dr && sel_prog && !push_ok)
      begin
        drop_q <= 1'b1;
      end
      else if (rise && in_cap_dr && sel_prog)
      begin
        drop_q <= 1'b0;
      end
    end
  end

  // one-cycle request pulses toward the nonvolatile store
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rb_q <= 1'b0;
      erase_q <= 1'b0;
      secure_q <= 1'b0;
    end
    else if (ce_in)
    begin
      rb_q <= rise & in_up_dr & sel_read & ~security_bit_in; // RULE13
      erase_q <= rise & in_up_ir & (ir_next == OP_ISP_ERASE); // RULE14
      secure_q <= rise & in_up_ir & (ir_next == OP_ISP_SECURE); // RULE12
    end
  end

  assign rb_req_out = rb_q;
  assign erase_req_out = erase_q;
  assign secure_req_out = secure_q;
  assign isp_active_out = sel_prog | sel_read | sel_erase | sel_secure;

  // program data buffer toward the programming engine
  jbs_fifo #(
    .WIDTH(DR_LEN),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .in_valid_in(pend_q),
    .in_ready_out(fifo_ready),
    .in_data_in(word_q),
    .out_valid_out(prog_valid_out),
    .out_ready_in(prog_ready_in),
    .out_data_out(prog_data_out)
  );

  // pad muxing: when disabled the four pins belong to the user
  assign pin_out[PIN_TCK] = tap_enable_in ? 1'b0 : user_out_in[PIN_TCK]; // RULE11
  assign pin_out[PIN_TMS] = tap_enable_in ? 1'b0 : user_out_in[PIN_TMS];
  assign pin_out[PIN_TDI] = tap_enable_in ? 1'b0 : user_out_in[PIN_TDI];
  assign pin_out[PIN_TDO] = tap_enable_in ? tdo_q : user_out_in[PIN_TDO];
  assign pin_oe_out[PIN_TCK] = tap_enable_in ? 1'b0 : user_oe_in[PIN_TCK]; // RULE11
  assign pin_oe_out[PIN_TMS] = tap_enable_in ? 1'b0 : user_oe_in[PIN_TMS];
  assign pin_oe_out[PIN_TDI] = tap_enable_in ? 1'b0 : user_oe_in[PIN_TDI];
  assign pin_oe_out[PIN_TDO] = tap_enable_in ? tdo_oe_q : user_oe_in[PIN_TDO];

endmodule

// ==== inc/jbs_pkg.sv ====
// shared constants, opcodes, states and carriers of the boundary-scan test port
package jbs_pkg;

  // register lengths
  localparam int IR_LEN = 10;
  localparam int DR_LEN = 32;
  localparam int BSR_LEN_DEFAULT = 288;
  localparam int SYNC_STAGES = 3;

  // instruction opcodes, chosen codes
  localparam logic [IR_LEN-1:0] OP_EXTEST = 10'h000;
  localparam logic [IR_LEN-1:0] OP_SAMPLE = 10'h055;
  localparam logic [IR_LEN-1:0] OP_IDCODE = 10'h059;
  localparam logic [IR_LEN-1:0] OP_ISP_PROGRAM = 10'h2f4;
  localparam logic [IR_LEN-1:0] OP_ISP_READ = 10'h205;
  localparam logic [IR_LEN-1:0] OP_ISP_ERASE = 10'h2f2;
  localparam logic [IR_LEN-1:0] OP_ISP_SECURE = 10'h2f9;
  localparam logic [IR_LEN-1:0] OP_BYPASS = 10'h3ff;
  localparam logic [IR_LEN-1:0] IR_CAPTURE = 10'h001;

  // identification fields; values are arbitrary
  localparam logic [3:0] ID_VERSION = 4'h1;
  localparam logic [15:0] ID_PART = 16'h5a3c;
  localparam logic [10:0] ID_MAKER = 11'h2a5;
  localparam logic ID_LSB = 1'b1;
  localparam logic [DR_LEN-1:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MAKER, ID_LSB};

  // status word captured under the program instruction
  localparam int ST_PEND_BIT = 0;
  localparam int ST_DROP_BIT = 1;

  // program data buffer
  localparam int FIFO_DEPTH = 16;

  // pad positions of the four test-port pins
  localparam int PIN_TCK = 0;
  localparam int PIN_TMS = 1;
  localparam int PIN_TDI = 2;
  localparam int PIN_TDO = 3;

  // tap controller states, one-hot
  typedef enum logic [15:0] {
    ST_TLR   = 16'h0001,
    ST_RTI   = 16'h0002,
    ST_SELDR = 16'h0004,
    ST_CAPDR = 16'h0008,
    ST_SHDR  = 16'h0010,
    ST_EX1DR = 16'h0020,
    ST_PSDR  = 16'h0040,
    ST_EX2DR = 16'h0080,
    ST_UPDR  = 16'h0100,
    ST_SELIR = 16'h0200,
    ST_CAPIR = 16'h0400,
    ST_SHIR  = 16'h0800,
    ST_EX1IR = 16'h1000,
    ST_PSIR  = 16'h2000,
    ST_EX2IR = 16'h4000,
    ST_UPIR  = 16'h8000
  } jbs_state_e;

  // the three sampled test-port inputs
  typedef struct packed {
    logic tdi;
    logic tms;
    logic tck;
  } jbs_pins_s;

endpackage

// ==== rtl/jbs_fifo.sv ====
// synchronous fifo with valid/ready on both sides
module jbs_fifo
  import jbs_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
)
(
  input wire logic ref_clk_in,             // system clock
  input wire logic resetn_in,              // async reset, active low
  input wire logic ce_in,                  // clock enable
  input wire logic in_valid_in,            // write request
  output logic in_ready_out,               // room available
  input wire logic [WIDTH-1:0] in_data_in, // write word
  output logic out_valid_out,              // word available
  input wire logic out_ready_in,           // reader takes word
  output logic [WIDTH-1:0] out_data_out    // head word
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire do_wr;
  wire do_rd;

  // handshake terms
  assign in_ready_out = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_q != '0);
  assign do_wr = in_valid_in & in_ready_out & ce_in;
  assign do_rd = out_valid_out & out_ready_in & ce_in;
  assign out_data_out = mem_q[rd_q];

  // storage, no reset needed
  always_ff @(posedge ref_clk_in)
  begin
    if (do_wr)
    begin
      mem_q[wr_q] <= in_data_in;
    end
  end

  // pointers and fill count
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (do_wr)
      begin
        wr_q <= wr_q + 1'b1;
      end
      if (do_rd)
      begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end

endmodule

// ==== tb/jbs_tap_sva.sv ====
// port assertions of the boundary-scan test port
module jbs_tap_sva
  import jbs_pkg::*;
#(
  parameter int BSR_LEN = BSR_LEN_DEFAULT,
  localparam int BSR_W = (BSR_LEN < 2) ? 1 : BSR_LEN
)
(
  input wire logic ref_clk_in, // clock
  input wire logic resetn_in, // reset
  input wire logic tap_enable_in, // port on
  input wire logic [3:0] pin_in, // pads
  input wire logic [3:0] pin_out, // pad level
  input wire logic [3:0] pin_oe_out, // pad enable
  input wire logic [3:0] user_out_in, // user level
  input wire logic [3:0] user_oe_in, // user enable
  input wire logic [BSR_W-1:0] core_out_in, // core
  input wire logic [BSR_W-1:0] pad_out, // pins
  input wire logic extest_out, // cells own pins
  input wire logic security_bit_in, // secured
  input wire logic rb_req_out, // readback
  input wire logic erase_req_out, // erase
  input wire logic secure_req_out, // secure
  input wire logic isp_active_out // programming
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);

  // pad ownership
  property p_user_pads;
    !tap_enable_in |-> pin_out == user_out_in && pin_oe_out == user_oe_in;
  endproperty
  a_user_pads: assert property (p_user_pads) else $error("pads not released");
  property p_inputs_free;
    tap_enable_in |-> pin_oe_out[2:0] == 3'h0;
  endproperty
  a_inputs_free: assert property (p_inputs_free) else $error("input pad driven");
  // tdo moves only after a tck edge
  property p_tdo_quiet;
    (tap_enable_in && $stable(pin_in[0])) [*8] |-> $stable(pin_out[3]) && $stable(pin_oe_out[3]);
  endproperty
  a_tdo_quiet: assert property (p_tdo_quiet) else $error("tdo moved without tck");
  // readback and programming requests
  property p_secure_read;
    security_bit_in |-> !rb_req_out;
  endproperty
  a_secure_read: assert property (p_secure_read) else $error("readback while secured");
  property p_rb_pulse;
    rb_req_out |=> !rb_req_out;
  endproperty
  a_rb_pulse: assert property (p_rb_pulse) else $error("readback pulse too long");
  property p_erase_pulse;
    $rose(erase_req_out) |-> isp_active_out ##1 !erase_req_out;
  endproperty
  a_erase_pulse: assert property (p_erase_pulse) else $error("bad erase pulse");
  property p_secure_pulse;
    secure_req_out |-> isp_active_out && !extest_out ##1 !secure_req_out;
  endproperty
  a_secure_pulse: assert property (p_secure_pulse) else $error("bad secure pulse");
  // pins follow the core unless extest
  property p_core_pass;
    !extest_out |-> pad_out == core_out_in;
  endproperty
  a_core_pass: assert property (p_core_pass) else $error("pins not from core");
  property p_extest_excl;
    extest_out |-> !isp_active_out;
  endproperty
  a_extest_excl: assert property (p_extest_excl) else $error("extest with programming");
endmodule

bind jbs_tap jbs_tap_sva #(.BSR_LEN(BSR_LEN)) i_sva (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
  .tap_enable_in(tap_enable_in), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
  .user_out_in(user_out_in), .user_oe_in(user_oe_in), .core_out_in(core_out_in), .pad_out(pad_out),
  .extest_out(extest_out), .security_bit_in(security_bit_in), .rb_req_out(rb_req_out),
  .erase_req_out(erase_req_out), .secure_req_out(secure_req_out), .isp_active_out(isp_active_out));

// ==== tb/jbs_ctl_model.sv ====
// behavioural test controller driving the link and sampling tdo
module jbs_ctl_model
(
  output logic tck_out, // test clock
  output logic tms_out, // mode select
  output logic tdi_out, // data in
  input wire logic tdo_in // data out
);
  timeunit 1ns;
  timeprecision 100ps;
  int half_ns = 24;

  // idle levels: clock still, data line at its pull-up
  initial
  begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
  end

  // one cycle: change on the fall, sample tdo late in the high phase
  task automatic tick(input logic m, input logic d, output logic q);
    tck_out = 1'b0;
    tms_out = m;
    tdi_out = d;
    #(half_ns);
    tck_out = 1'b1;
    #(half_ns - 1);
    q = tdo_in;
    #1;
  endtask

  // end of frame: clock stops low
  task automatic rest;
    tck_out = 1'b0;
    tdi_out = 1'b1;
    #(half_ns);
  endtask

  // five ones reach test-logic reset, then idle
  task automatic go_idle;
    logic q;
    repeat (5) tick(1'b1, 1'b1, q);
    tick(1'b0, 1'b1, q);
    rest;
  endtask

  // scan from idle back to idle, lsb first
  task automatic scan(input bit ir, input int n, input logic [511:0] din, output logic [511:0] dout);
    logic q;
    dout = '0;
    tick(1'b1, 1'b1, q);
    if (ir)
      tick(1'b1, 1'b1, q);
    tick(1'b0, 1'b1, q);
    tick(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, din[i], q);
      dout[i] = q;
    end
    tick(1'b1, 1'b1, q);
    tick(1'b0, 1'b1, q);
    rest;
  endtask
endmodule

// ==== tb/tb_jbs_tap.sv ====
// self-checking bench of the boundary-scan test port
module tb_jbs_tap;
  import jbs_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BL = 288;
  logic clk = 1'b0;
  logic rstn, tap_en, sec, prog_ready, tck, tms, tdi, tdo_w, extest, rb_req, erase_req, secure_req, isp_act, prog_valid;
  logic ce;
  logic [3:0] user_o, user_oe, pin_o, pin_oe, pin_i;
  logic [BL-1:0] pad_i, core_o, pad_o;
  logic [31:0] rb_data, prog_data;
  int miscompares = 0;
  int n_tests = 0;
  int n_rb = 0;
  int n_er = 0;
  int n_se = 0;
  logic [31:0] id = {4'h1, 16'h5a3c, 11'h2a5, 1'b1};

  always #2.5 clk = ~clk;
  // pulled-up tdo wire and pad levels
  assign tdo_w = pin_oe[3] ? pin_o[3] : 1'b1;
  assign pin_i = {tdo_w, tdi, tms, tck};

  jbs_tap #(.BSR_LEN(BL)) i_dut (.ref_clk_in(clk), .resetn_in(rstn), .ce_in(ce), .tap_enable_in(tap_en),
    .pin_in(pin_i), .pin_out(pin_o), .pin_oe_out(pin_oe), .user_out_in(user_o), .user_oe_in(user_oe),
    .pad_in(pad_i), .core_out_in(core_o), .pad_out(pad_o), .extest_out(extest), .security_bit_in(sec),
    .rb_data_in(rb_data), .rb_req_out(rb_req), .erase_req_out(erase_req), .secure_req_out(secure_req),
    .isp_active_out(isp_act), .prog_valid_out(prog_valid), .prog_ready_in(prog_ready), .prog_data_out(prog_data));
  jbs_ctl_model i_ctl (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo_w));

  // count request pulses
  always @(posedge clk)
  begin
    n_rb <= n_rb + (rb_req === 1'b1);
    n_er <= n_er + (erase_req === 1'b1);
    n_se <= n_se + (secure_req === 1'b1);
  end

  task automatic at_edge;
    @(posedge clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [511:0] exp, input logic [511:0] got);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic load_ir(input logic [IR_LEN-1:0] op);
    logic [511:0] d;
    i_ctl.scan(1'b1, IR_LEN, {502'h0, op}, d);
    chk("ir capture", 512'h1, d);
  endtask

  task automatic t_idcode;
    logic [511:0] d;
    i_ctl.go_idle;
    i_ctl.scan(1'b0, 32, '0, d);
    chk("idcode", {480'h0, id}, d);
  endtask

  task automatic t_bypass;
    logic [511:0] d;
    load_ir(OP_BYPASS);
    i_ctl.half_ns = 60;
    i_ctl.scan(1'b0, 9, 512'h0b5, d);
    chk("bypass", 512'h16a, d);
    i_ctl.half_ns = 24;
    load_ir(10'h123);
    i_ctl.scan(1'b0, 9, 512'h0b5, d);
    chk("unknown op", 512'h16a, d);
  endtask

  task automatic t_boundary;
    logic [511:0] d;
    logic [BL-1:0] p;
    p = {9{32'h3c5a_e187}};
    at_edge;
    pad_i = ~p;
    core_o = {9{32'h0f0f_1234}};
    load_ir(OP_SAMPLE);
    i_ctl.scan(1'b0, BL, {224'h0, p}, d);
    chk("sample capture", {224'h0, ~p}, d);
    chk("core passes", {224'h0, core_o}, {224'h0, pad_o});
    load_ir(OP_EXTEST);
    chk("extest flag", 512'h1, {511'h0, extest});
    chk("preload drive", {224'h0, p}, {224'h0, pad_o});
    at_edge;
    pad_i = p;
    i_ctl.scan(1'b0, BL, {224'h0, ~p}, d);
    chk("extest capture", {224'h0, p}, d);
    chk("extest drive", {224'h0, ~p}, {224'h0, pad_o});
  endtask

  task automatic t_readback;
    logic [511:0] d;
    int r0;
    load_ir(OP_ISP_READ);
    chk("isp active", 512'h1, {511'h0, isp_act});
    r0 = n_rb;
    i_ctl.scan(1'b0, 32, '0, d);
    chk("readback", {480'h0, rb_data}, d);
    chk("readback pulse", r0 + 1, n_rb);
    at_edge;
    sec = 1'b1;
    i_ctl.scan(1'b0, 32, '0, d);
    chk("secured readback", 512'h0, d);
    chk("secured pulse", r0 + 1, n_rb);
    load_ir(OP_ISP_ERASE);
    load_ir(OP_ISP_SECURE);
    chk("erase pulse", 1, n_er);
    chk("secure pulse", 1, n_se);
    at_edge;
    sec = 1'b0;
  endtask

  task automatic t_program;
    logic [511:0] d;
    load_ir(OP_ISP_PROGRAM);
    for (int k = 0; k < 19; k++)
      i_ctl.scan(1'b0, 32, 512'ha500 + k, d);
    chk("status", 512'h3, d);
    for (int k = 0; k < 17; k++)
    begin
      for (int t = 0; t < 20 && prog_valid !== 1'b1; t++)
        at_edge;
      chk("word valid", 512'h1, {511'h0, prog_valid});
      chk("program word", 512'ha500 + k, {480'h0, prog_data});
      at_edge;
      prog_ready = 1'b1;
      at_edge;
      prog_ready = 1'b0;
    end
    repeat (4) at_edge;
    chk("fifo empty", 512'h0, {511'h0, prog_valid});
  endtask

  task automatic t_disable;
    logic [511:0] d;
    logic q;
    load_ir(OP_BYPASS);
    // a frame sent while the clock enable is low must leave the instruction alone
    at_edge;
    ce = 1'b0;
    i_ctl.scan(1'b1, IR_LEN, 512'h0, d);
    at_edge;
    ce = 1'b1;
    i_ctl.scan(1'b0, 9, 512'h0b5, d);
    chk("ce freeze", 512'h16a, d);
    at_edge;
    tap_en = 1'b0;
    at_edge;
    chk("user pads", {504'h0, user_oe, user_o}, {504'h0, pin_oe, pin_o});
    i_ctl.scan(1'b1, IR_LEN, 512'h0, d);
    at_edge;
    tap_en = 1'b1;
    // no reset sequence here: only the forced reset while disabled may restore the id
    i_ctl.tick(1'b0, 1'b1, q);
    i_ctl.rest;
    i_ctl.scan(1'b0, 32, '0, d);
    chk("id after disable", {480'h0, id}, d);
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // main sequence
  initial
  begin
    rstn = 1'b0;
    ce = 1'b1;
    tap_en = 1'b1;
    user_o = 4'h5;
    user_oe = 4'ha;
    pad_i = '0;
    core_o = '0;
    sec = 1'b0;
    rb_data = 32'hc3a5_0f1e;
    prog_ready = 1'b0;
    repeat (10) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (4) at_edge;
    t_idcode;
    t_bypass;
    t_boundary;
    t_readback;
    t_program;
    t_disable;
    complete_run;
  end

  // watchdog
  initial
  begin
    repeat (90000) @(posedge clk);
    miscompares++;
    complete_run;
  end
endmodule
